// ### verilog/ees_pkg.sv
// Purpose: Shared constants and carrier types for the two-wire EEPROM slave.
// Assumes: 20 MHz system clock; bus pins arrive asynchronous to it.
// Notes:   Timing counts derive from printed times and the clock rate.
package ees_pkg;
  // Clock and timing
  localparam int EES_CLK_HZ = 20_000_000;
  localparam int EES_T_WRITE_MS = 5;
  localparam int EES_WRITE_CYC = EES_T_WRITE_MS * (EES_CLK_HZ / 1000);
  // Organisation
  localparam int EES_ADDR_W = 15;
  localparam int EES_MEM_BYTES = 32768;
  localparam int EES_PAGE_BYTES = 64;
  localparam int EES_OFF_W = 6;
  localparam int EES_PAGE_W = 9;
  localparam int EES_FIFO_DEPTH = 2;
  // Slave address layout; type code value is arbitrary
  localparam logic [3:0] EES_DEV_TYPE = 4'h5;
  localparam int EES_DEV_TYPE_POS = 4;
  localparam int EES_STRAP_POS = 1;
  localparam int EES_RW_POS = 0;
  // Sync vector layout
  localparam int EES_SY_SCL = 0;
  localparam int EES_SY_SDA = 1;
  localparam int EES_SY_WP = 2;
  localparam int EES_SY_STRAP = 3;
  localparam int EES_SY_W = 6;
  // Reset value and ack-slot bit count
  localparam logic EES_STANDBY_RST = 1'b1;
  localparam logic [3:0] EES_BIT_ACK = 4'h8;
  // Bus lines idle high; protect and straps start low
  localparam logic [5:0] EES_SYNC_RST = 6'h03;
  localparam logic EES_LINE_IDLE = 1'b1;

  typedef enum logic [2:0] {
    EES_IDLE = 3'b000,
    EES_DEV = 3'b001,
    EES_ADRH = 3'b010,
    EES_ADRL = 3'b011,
    EES_WDATA = 3'b100,
    EES_RDATA = 3'b101
  } ees_phase_e;

  // One received byte on its way to the page buffer
  typedef struct packed {
    logic [5:0] off;
    logic [7:0] data;
  } ees_fent_s;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic scl_d;
    logic sda_d;
    ees_phase_e ph;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic ackslot;
    logic drv;
    logic mack;
    logic [14:0] addr;
    logic [8:0] page;
    logic [63:0] valid;
    logic wr_pend;
    logic go;
    logic busy;
    logic [23:0] tmr;
    logic standby;
    logic [1:0] cnt;
    ees_fent_s [1:0] fq;
  } ees_state_s;
endpackage

// ### verilog/ees_twowire_slave.sv
// Purpose: Two-wire serial slave front end of a 32K x 8 nonvolatile memory.
// Assumes: Bus lines sampled by mclk, which runs far faster than the bus clock.
// Notes:   Open-drain data pin: sda_out is always low, sda_oe pulls the line.
`timescale 1ns/1ps

module ees_twowire_slave #(
  parameter int WRITE_CYCLES = ees_pkg::EES_WRITE_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wp_in,
  input wire logic select_strap_bit2,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit0,
  output logic standby,
  output logic write_busy
);
  import ees_pkg::*;

  ees_state_s r_reg;
  ees_state_s r_next;
  logic [7:0] mem [0:EES_MEM_BYTES-1];
  logic [7:0] pbuf [0:EES_PAGE_BYTES-1];
  logic pop;
  logic commit_en;
  logic scl;
  logic sda;
  logic wp;
  logic [2:0] strap;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_hit;
  ees_fent_s ent;

  // In-page increment; upper page bits are never touched
  function automatic logic [14:0] ees_page_next(input logic [14:0] a);
    ees_page_next = {a[14:6], 6'(a[5:0] + 6'h1)};
  endfunction

  // Settled pin levels come only from the second stage
  assign scl = r_reg.sync2[EES_SY_SCL];
  assign sda = r_reg.sync2[EES_SY_SDA];
  assign wp = r_reg.sync2[EES_SY_WP];
  assign strap = r_reg.sync2[EES_SY_STRAP +: 3];
  assign scl_rise = scl & ~r_reg.scl_d;
  assign scl_fall = ~scl & r_reg.scl_d;
  assign start_det = scl & r_reg.scl_d & r_reg.sda_d & ~sda;
  assign stop_det = scl & r_reg.scl_d & ~r_reg.sda_d & sda;
  assign addr_hit = (r_reg.shreg[EES_DEV_TYPE_POS +: 4] == EES_DEV_TYPE)
                    && (r_reg.shreg[EES_STRAP_POS +: 3] == strap) && !r_reg.busy;
  assign ent = '{off: r_reg.addr[5:0], data: r_reg.shreg};

  // Registered outputs; open-drain so only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe = r_reg.drv;
  assign standby = r_reg.standby;
  assign write_busy = r_reg.busy;

  // Next-state logic for the whole slave
  always_comb begin
    r_next = r_reg;
    r_next.sync1 = {select_strap_bit2, select_strap_bit1, select_strap_bit0,
                    wp_in, sda_in, scl_in};
    r_next.sync2 = r_reg.sync1;
    r_next.scl_d = scl;
    r_next.sda_d = sda;
    // Buffer drains into the page buffer unless programming is running
    pop = (r_reg.cnt != 2'h0) && !r_reg.busy;
    commit_en = r_reg.busy && (r_reg.tmr < 24'(EES_PAGE_BYTES));
    if (pop) begin
      r_next.valid[r_reg.fq[0].off] = 1'b1;
      r_next.fq[0] = r_reg.fq[1];
      r_next.cnt = 2'(r_reg.cnt - 2'h1);
    end
    if ((scl != r_reg.scl_d) || (sda != r_reg.sda_d)) begin
      r_next.standby = 1'b0;
    end
    if (r_reg.busy) begin
      r_next.tmr = 24'(r_reg.tmr + 24'h1);
      if (r_reg.tmr == 24'(WRITE_CYCLES - 1)) begin
        r_next.busy = 1'b0;
        r_next.valid = '0;
        r_next.standby = 1'b1;
      end
    end else if (r_reg.go && (r_reg.cnt == 2'h0)) begin
      // programming begins once the buffer is empty
      r_next.go = 1'b0;
      r_next.busy = 1'b1;
      r_next.tmr = '0;
    end
    if (start_det) begin
      // start aborts the bus transfer in progress; a pending or running write cycle goes on
      r_next.ph = EES_DEV;
      r_next.bitcnt = '0;
      r_next.ackslot = 1'b0;
      r_next.drv = 1'b0;
      if (!r_reg.go && !r_reg.busy) begin
        r_next.valid = '0;
        r_next.wr_pend = 1'b0;
      end
    end else if (stop_det) begin
      r_next.ph = EES_IDLE;
      r_next.drv = 1'b0;
      r_next.wr_pend = 1'b0;
      // protected data is dropped at the stop
      if (r_reg.wr_pend && !wp) begin
        r_next.go = 1'b1;
      end else if (!r_reg.go && !r_reg.busy) begin
        r_next.valid = '0;
        // stop without write enters standby, never while programming
        r_next.standby = 1'b1;
      end
    end else if (r_reg.ph != EES_IDLE) begin
      // bit engine only runs after a start
      if (scl_rise) begin
        if (!r_reg.ackslot) begin
          r_next.shreg = {r_reg.shreg[6:0], sda};
          r_next.bitcnt = 4'(r_reg.bitcnt + 4'h1);
        end else if (r_reg.ph == EES_RDATA) begin
          r_next.mack = ~sda;
        end
      end else if (scl_fall) begin
        if (!r_reg.ackslot && (r_reg.bitcnt == EES_BIT_ACK)) begin
          r_next.ackslot = 1'b1;
          r_next.drv = 1'b0;
          unique case (r_reg.ph)
            EES_DEV: begin
              if (addr_hit) begin
                r_next.drv = 1'b1;
                r_next.mack = 1'b1;
                r_next.ph = r_reg.shreg[EES_RW_POS] ? EES_RDATA : EES_ADRH;
              end else begin
                r_next.ph = EES_IDLE;
              end
            end
            EES_ADRH: begin
              r_next.addr[14:8] = r_reg.shreg[6:0];
              r_next.drv = 1'b1;
              r_next.ph = EES_ADRL;
            end
            EES_ADRL: begin
              r_next.addr[7:0] = r_reg.shreg;
              // Low page bits arrive in this byte, not in the old counter
              r_next.page = {r_reg.addr[14:8], r_reg.shreg[7:6]};
              r_next.drv = 1'b1;
              r_next.ph = EES_WDATA;
            end
            EES_WDATA: begin
              // ack each data byte while the buffer has room
              if (r_reg.cnt != 2'(EES_FIFO_DEPTH)) begin
                r_next.drv = 1'b1;
                r_next.fq[r_next.cnt[0]] = ent;
                r_next.cnt = 2'(r_next.cnt + 2'h1);
                r_next.wr_pend = 1'b1;
                r_next.addr = ees_page_next(r_reg.addr);
              end
            end
            EES_RDATA: begin
              r_next.drv = 1'b0;
            end
            default: begin
              r_next.ph = EES_IDLE;
            end
          endcase
        end else if (r_reg.ackslot) begin
          // End of ninth clock: release, or load the next read byte
          r_next.ackslot = 1'b0;
          r_next.bitcnt = '0;
          r_next.drv = 1'b0;
          if (r_reg.ph == EES_RDATA) begin
            if (r_reg.mack) begin
              r_next.shreg = mem[r_reg.addr];
              r_next.drv = ~mem[r_reg.addr][7];
              r_next.addr = 15'(r_reg.addr + 15'h1);
            end else begin
              r_next.ph = EES_IDLE;
            end
          end
        end else if (r_reg.ph == EES_RDATA) begin
          // change data only while clock low
          r_next.drv = ~r_reg.shreg[7];
        end
      end
    end
  end

  // State register; standby is the power-up condition
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.standby <= EES_STANDBY_RST;
      // Idle-high line history, so release shows no false toggle
      r_reg.sync1 <= EES_SYNC_RST;
      r_reg.sync2 <= EES_SYNC_RST;
      r_reg.scl_d <= EES_LINE_IDLE;
      r_reg.sda_d <= EES_LINE_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Page buffer fill from the two-entry buffer
  always_ff @(posedge mclk) begin
    if (pop) begin
      pbuf[r_reg.fq[0].off] <= r_reg.fq[0].data;
    end
  end

  // only the received (valid) bytes of the page are committed, in the first 64 cycles of the write cycle
  always_ff @(posedge mclk) begin
    if (commit_en && r_reg.valid[r_reg.tmr[5:0]]) begin
      mem[{r_reg.page, r_reg.tmr[5:0]}] <= pbuf[r_reg.tmr[5:0]];
    end
  end
endmodule // ees_twowire_slave

// ### testbench/ees_twowire_slave_asserts.sv
// Purpose: Port checks on the two-wire slave.
// Assumes: Bus half period of 4 mclk.
// Notes:   Busy length allows one cycle of slack.
`timescale 1ns/1ps
module ees_twowire_slave_asserts #(
  parameter int WRITE_CYCLES = 200
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic wp_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic standby,
  input wire logic write_busy
);
  logic [23:0] busy_cnt_reg;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Busy cycles, cleared while idle
  always_ff @(posedge mclk) begin
    if (!nrst || !write_busy) busy_cnt_reg <= 24'h0;
    else busy_cnt_reg <= busy_cnt_reg + 24'h1;
  end
  chk_oe_steady_high: assert property ($rose(scl_in) |-> ##2 $stable(sda_oe)[*2])
    else $error("data drive moved while clock high");
  chk_ack_full_slot: assert property ($rose(sda_oe) |=> sda_oe[*6])
    else $error("ack drive too short");
  chk_busy_no_ack: assert property (write_busy |-> !$rose(sda_oe))
    else $error("answer while busy");
  chk_busy_length: assert property ($fell(write_busy) |->
    busy_cnt_reg inside {[WRITE_CYCLES-1:WRITE_CYCLES+1]})
    else $error("write cycle length wrong");
  chk_busy_then_standby: assert property ($fell(write_busy) |-> ##[0:2] standby)
    else $error("no standby after write");
  chk_busy_not_standby: assert property (write_busy |-> !standby)
    else $error("standby while busy");
  chk_protect_no_write: assert property (wp_in && $past(wp_in, 8) |-> !$rose(write_busy))
    else $error("write cycle while protected");
  chk_standby_wakes: assert property (standby && $fell(sda_in) |-> ##[1:8] !standby)
    else $error("standby kept after toggle");
  chk_drive_low_only: assert property (sda_oe |-> !sda_out && !standby)
    else $error("data driven high");
endmodule // ees_twowire_slave_asserts

// ### testbench/ees_bus_master.sv
// Purpose: Behavioural two-wire bus master.
// Assumes: Data wire resolved outside with pull-up; 1 releases.
// Notes:   Clock stands high between frames; period 8 mclk.
`timescale 1ns/1ps
module ees_bus_master (
  input wire logic mclk,
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hp();
    repeat (4) @(negedge mclk);
  endtask
  task automatic start();
    @(negedge mclk);
    sda_drv = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_drv = 1'b0;
    hp();
    scl = 1'b0;
  endtask
  task automatic stop();
    @(negedge mclk);
    sda_drv = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_drv = 1'b1;
    hp();
  endtask
  // data moves a cycle after clock falls
  task automatic bit_io(input logic b, output logic r);
    @(negedge mclk);
    sda_drv = b;
    repeat (3) @(negedge mclk);
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, r);
    ack = !r;
  endtask
endmodule // ees_bus_master

// ### testbench/test_ees_twowire_slave.sv
// Purpose: Self-checking bench for the two-wire slave.
// Assumes: Write cycle shortened to 200 mclk.
// Notes:   Reads only confirm what page writes stored.
`timescale 1ns/1ps
module test_ees_twowire_slave;
  import ees_pkg::*;
  localparam int WCYC = 200;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h5;
  logic scl, sda_drv, sda_out, sda_oe, standby, write_busy, a;
  logic [7:0] q;
  wire sda = sda_drv & ~(sda_oe & ~sda_out);
  int bad_count = 0;
  int num_checks = 0;
  initial forever #25 mclk = ~mclk;
  ees_twowire_slave #(.WRITE_CYCLES(WCYC)) dut (.mclk(mclk), .nrst(nrst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp),
    .select_strap_bit2(strap[2]), .select_strap_bit1(strap[1]),
    .select_strap_bit0(strap[0]), .standby(standby), .write_busy(write_busy));
  ees_bus_master m (.mclk(mclk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait for the write cycle flag
  task automatic wait_busy(input logic lvl);
    int n = 0;
    while (write_busy !== lvl && n < 2 * WCYC) begin
      @(negedge mclk);
      n++;
    end
    check("busy", 8'(write_busy), 8'(lvl));
    if (write_busy !== lvl) report_and_stop();
  endtask
  function automatic logic [7:0] dev(input logic [2:0] s, input logic rw);
    return {EES_DEV_TYPE, s, rw};
  endfunction
  task automatic send(input logic [7:0] d, input logic exp);
    m.xfer(d, 1'b1, q, a);
    check("ack", 8'(a), 8'(exp));
  endtask
  // Dummy write cut by a repeated start, then one byte back
  task automatic read_at(input logic [7:0] lo, input logic [7:0] exp);
    m.start();
    send(dev(strap, 1'b0), 1'b1);
    send(8'h7f, 1'b1);
    send(lo, 1'b1);
    m.start();
    send(dev(strap, 1'b1), 1'b1);
    m.xfer(8'hff, 1'b1, q, a);
    m.stop();
    check("data", q, exp);
  endtask
  task automatic t_addr();
    for (int s = 0; s < 8; s++) begin
      m.start();
      send(dev(3'(s), 1'b0), 3'(s) == strap);
      m.stop();
    end
    m.start();
    send({~EES_DEV_TYPE, strap, 1'b0}, 1'b0);
    m.stop();
    repeat (20) @(negedge mclk);
    check("idle stop", 8'({write_busy, standby}), 8'h01);
  endtask
  // Page write of 65 bytes from offset 3e, so the last overwrites the first
  task automatic t_page();
    m.start();
    send(dev(strap, 1'b0), 1'b1);
    send(8'hff, 1'b1);
    send(8'hbe, 1'b1);
    for (int k = 1; k <= 65; k++) send(8'(k), 1'b1);
    m.stop();
    wait_busy(1'b1);
    m.start();
    send(dev(strap, 1'b0), 1'b0);
    m.stop();
    wait_busy(1'b0);
    repeat (2) @(negedge mclk);
    check("standby", 8'(standby), 8'h01);
    read_at(8'hbe, 8'h41);
    read_at(8'h80, 8'h03);
  endtask
  // Current-address read after the last read, then one sequential byte
  task automatic t_seq();
    m.start();
    send(dev(strap, 1'b1), 1'b1);
    m.xfer(8'hff, 1'b0, q, a);
    check("next data", q, 8'h04);
    m.xfer(8'hff, 1'b1, q, a);
    m.stop();
    check("seq data", q, 8'h05);
  endtask
  task automatic t_wp();
    wp = 1'b1;
    m.start();
    send(dev(strap, 1'b0), 1'b1);
    send(8'h00, 1'b1);
    send(8'h10, 1'b1);
    send(8'h5a, 1'b1);
    m.stop();
    repeat (40) @(negedge mclk);
    check("protected", 8'({write_busy, standby}), 8'h01);
    wp = 1'b0;
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    check("reset", 8'({sda_oe, write_busy, standby}), 8'h01);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    check("standby idle", 8'(standby), 8'h01);
    t_addr();
    t_page();
    t_seq();
    t_wp();
    report_and_stop();
  end
endmodule // test_ees_twowire_slave
bind ees_twowire_slave ees_twowire_slave_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .mclk(mclk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .wp_in(wp_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .standby(standby), .write_busy(write_busy));
